//--- rtl/rscl_strap_sampler.sv
// Strap configuration package and the strap capture register.
// Assumes strap levels are synchronous to clk and a one-cycle capture
// pulse marks the trailing edge of the system reset.
`timescale 1ns/1ps
`default_nettype none

package rscl_pkg;
   // Straps as seen on the dual-use pins while system reset is asserted
   typedef struct packed {
      logic test;
      logic supplyPol;
      logic pled1;
      logic pled0;
      logic baseSel;
   } rscl_straps_t;

   localparam rscl_straps_t STRAPS_RESET = 5'h00;

   // Configuration index/data pair locations
   localparam logic [15:0] CFG_BASE_LOW  = 16'h002e;
   localparam logic [15:0] CFG_BASE_HIGH = 16'h004e;

   // Register port map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CTRL   = 8'h04;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Status field positions
   localparam int ST_BASE  = 0;
   localparam int ST_PLED0 = 1;
   localparam int ST_PLED1 = 2;
   localparam int ST_POL   = 3;
   localparam int ST_TEST  = 4;
   localparam int ST_VALID = 5;
   localparam int ST_PINC  = 6;
   localparam int ST_PIND  = 7;

   // Control field positions
   localparam int CT_PWRBTN = 0;
   localparam int CT_SUPPLY = 1;
   localparam int CT_GPOUT0 = 2;
   localparam int CT_GPOUT1 = 3;

   // Capture sequencer, Gray coded along wait -> in reset -> run
   typedef enum logic [1:0] {
      CAP_WAIT  = 2'b00,
      CAP_INRST = 2'b01,
      CAP_RUN   = 2'b11
   } rscl_cap_state_t;
endpackage

////////////////////////////////////////////////////////////////////////

module rscl_strap_sampler (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Capture
   input  wire logic                capture,
   input  wire rscl_pkg::rscl_straps_t strapsIn,
   // Held configuration
   output rscl_pkg::rscl_straps_t   cfgOut
);
   import rscl_pkg::*;

   rscl_straps_t cfg_q;
   rscl_straps_t cfg_d;

   // Value only changes on the capture pulse, so it is static between resets
   assign cfg_d = capture ? strapsIn : cfg_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) cfg_q <= STRAPS_RESET;
      else          cfg_q <= cfg_d;
   end

   assign cfgOut = cfg_q;
endmodule // rscl_strap_sampler

`default_nettype wire

//--- rtl/rscl_strap_config_latch.sv
// Reset strap configuration latch: captures straps at the trailing edge
// of system reset and applies them to decode and shared pin functions.
// Assumes all inputs synchronous to clk; pad wiring resolves out/oe.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rscl_strap_config_latch (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset_n,
   // System reset, level
   input  wire logic               sysReset_n,
   // Strap pins: base select / terminal ready pin
   input  wire logic               baseSelPinIn,
   output logic                    baseSelPinOut,
   output logic                    baseSelPinOe,
   // Strap pins: test / request to send pin
   input  wire logic               testPinIn,
   output logic                    testPinOut,
   output logic                    testPinOe,
   // Other straps, sampled only
   input  wire logic               power_led_pin_cfg_strap0,
   input  wire logic               power_led_pin_cfg_strap1,
   input  wire logic               supply_on_polarity_strap,
   // Serial port 1 core side
   input  wire logic               uartTermReady,
   input  wire logic               uartReqToSend,
   input  wire logic               uartBaudSel,
   input  wire logic               uartBaudClk,
   // Shared pin A: power_button_out / standby_gp_out0
   output logic                    pinAOut,
   output logic                    pinAOe,
   // Shared pin B: supply_on_out / standby_gp_out1
   output logic                    pinBOut,
   output logic                    pinBOe,
   // Shared pin C: power_button_in / standby_gp_in2
   input  wire logic               pinCIn,
   // Shared pin D: deep_sleep_state_in / analog_voltage_in0
   input  wire logic               pinDIn,
   // Decoded pin functions toward the chip
   output logic                    powerButtonIn_n,
   output logic                    deepSleepStateIn_n,
   output logic                    standbyGpIn2,
   output logic                    analogIn0Select,
   // Configuration decode
   input  wire logic               ioValid,
   input  wire logic [15:0]        ioAddr,
   output logic                    cfgIndexHit,
   output logic                    cfgDataHit,
   output logic                    testModeActive,
   // Register port
   input  wire logic [7:0]         regAddr,
   input  wire logic [7:0]         regWdata,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic [7:0]              regRdata
);
   import rscl_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Address decode helper, used for both halves of the pair

   function automatic logic cfgAddrMatch(input logic [15:0] addr, input logic [15:0] base,
                                         input logic odd);
      cfgAddrMatch = (addr[15:1] == base[15:1]) && (addr[0] == odd);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Capture sequencer

   rscl_cap_state_t state_q;
   rscl_cap_state_t state_d;
   logic            capturePulse;
   rscl_straps_t    strapsNow;
   rscl_straps_t    cfg;

   // Pins are still straps in the cycle the system reset releases
   assign strapsNow.baseSel   = baseSelPinIn;
   assign strapsNow.pled0     = power_led_pin_cfg_strap0;
   assign strapsNow.pled1     = power_led_pin_cfg_strap1;
   assign strapsNow.supplyPol = supply_on_polarity_strap;
   assign strapsNow.test      = testPinIn;

   assign capturePulse = (state_q == CAP_INRST) && sysReset_n;

   always_comb begin
      case (state_q)
         CAP_WAIT:  state_d = sysReset_n ? CAP_WAIT : CAP_INRST;
         CAP_INRST: state_d = sysReset_n ? CAP_RUN : CAP_INRST;
         CAP_RUN:   state_d = sysReset_n ? CAP_RUN : CAP_INRST;
         default:   state_d = CAP_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) state_q <= CAP_WAIT;
      else          state_q <= state_d;
   end

   // Captured once per trailing edge, static afterwards
   rscl_strap_sampler u_sampler (
      .clk      (clk),
      .reset_n  (reset_n),
      .capture  (capturePulse),
      .strapsIn (strapsNow),
      .cfgOut   (cfg)
   );

   wire cfgValid = (state_q == CAP_RUN);
   wire gpMode   = cfg.pled0 & cfg.pled1;

   ////////////////////////////////////////////////////////////////////
   // Configuration pair decode

   wire [15:0] cfgBase = cfg.baseSel ? CFG_BASE_HIGH : CFG_BASE_LOW;

   assign cfgIndexHit    = ioValid && cfgValid && cfgAddrMatch(ioAddr, cfgBase, 1'b0);
   assign cfgDataHit     = ioValid && cfgValid && cfgAddrMatch(ioAddr, cfgBase, 1'b1);
   assign testModeActive = cfgValid && cfg.test;

   ////////////////////////////////////////////////////////////////////
   // Register port

   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] statusWord;

   assign statusWord = {pinDIn, pinCIn, cfgValid, cfg.test, cfg.supplyPol,
                        cfg.pled1, cfg.pled0, cfg.baseSel};
   assign ctrl_d  = (regWrite && regAddr == REG_CTRL) ? regWdata : ctrl_q;
   // Unmapped addresses read as zero
   assign rdata_d = !regRead             ? 8'h00 :
                    (regAddr == REG_STATUS) ? statusWord :
                    (regAddr == REG_CTRL)   ? ctrl_q : 8'h00;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q  <= CTRL_RESET;
         rdata_q <= 8'h00;
      end else begin
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   assign regRdata = rdata_q;

   ////////////////////////////////////////////////////////////////////
   // Shared power / standby pins

   wire pwrBtnReq = ctrl_q[CT_PWRBTN];
   wire supplyReq = ctrl_q[CT_SUPPLY];

   // Supply-on: open drain low, or push-pull high, chosen by strap
   wire supplyOut = cfg.supplyPol ? supplyReq : 1'b0;
   wire supplyOe  = cfg.supplyPol ? 1'b1      : supplyReq;

   // Pins stay released until a strap set has been captured
   assign pinAOut = gpMode ? ctrl_q[CT_GPOUT0] : 1'b0;
   assign pinAOe  = cfgValid && (gpMode ? 1'b1 : pwrBtnReq);
   assign pinBOut = gpMode ? ctrl_q[CT_GPOUT1] : supplyOut;
   assign pinBOe  = cfgValid && (gpMode ? 1'b1 : supplyOe);

   // Unused function of an input pin reads as its idle level
   assign powerButtonIn_n    = (cfgValid && !gpMode) ? pinCIn : 1'b1;
   assign deepSleepStateIn_n = (cfgValid && !gpMode) ? pinDIn : 1'b1;
   assign standbyGpIn2       = (cfgValid && gpMode) ? pinCIn : 1'b0;
   assign analogIn0Select    = cfgValid && gpMode;

   ////////////////////////////////////////////////////////////////////
   // Serial port 1 pins after reset

   // Released during system reset so board pulls set the straps
   assign baseSelPinOe  = cfgValid;
   assign baseSelPinOut = uartBaudSel ? uartBaudClk : !uartTermReady;
   assign testPinOe     = cfgValid;
   assign testPinOut    = !uartReqToSend;

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   base_capture_a: assert property (capturePulse |=> cfg.baseSel == $past(baseSelPinIn))
      else $error("base select not captured at reset release");

   low_base_decode_a: assert property (
      cfgValid && !cfg.baseSel && ioValid && ioAddr == 16'h002f |-> cfgDataHit && !cfgIndexHit)
      else $error("low base data decode wrong");

   high_base_decode_a: assert property (
      cfgValid && cfg.baseSel && ioValid && ioAddr == 16'h004e |-> cfgIndexHit && !cfgDataHit)
      else $error("high base index decode wrong");

   power_pin_mode_a: assert property (
      cfgValid && !gpMode |-> pinAOut == 1'b0 && pinAOe == pwrBtnReq && powerButtonIn_n == pinCIn)
      else $error("power pin function wrong");

   standby_pin_mode_a: assert property (
      cfgValid && gpMode |-> pinAOe && pinBOe && standbyGpIn2 == pinCIn && analogIn0Select)
      else $error("standby pin function wrong");

   supply_open_drain_a: assert property (
      cfgValid && !gpMode && !cfg.supplyPol |-> pinBOut == 1'b0 && pinBOe == supplyReq)
      else $error("supply-on not open drain active low");

   supply_push_pull_a: assert property (
      cfgValid && !gpMode && cfg.supplyPol |-> pinBOe && pinBOut == supplyReq)
      else $error("supply-on not push-pull active high");

   test_mode_entry_a: assert property (
      capturePulse && testPinIn |=> testModeActive [*2])
      else $error("test mode not entered");

   straps_held_a: assert property (
      !capturePulse |=> $stable(cfg))
      else $error("straps changed outside capture");

   serial_release_a: assert property (
      !sysReset_n |=> !baseSelPinOe && !testPinOe)
      else $error("serial pin driven during system reset");

   rts_after_reset_a: assert property (
      capturePulse ##1 !uartReqToSend |-> testPinOe && testPinOut)
      else $error("request-to-send not inactive high after reset");

   status_read_a: assert property (regRead && regAddr == REG_STATUS |=> regRdata == $past(statusWord))
      else $error("status read data wrong");

   // Decode of the pair, both halves and the foreign base
   low_base_index_a: assert property (
      cfgValid && !cfg.baseSel && ioValid && ioAddr == CFG_BASE_LOW |-> cfgIndexHit && !cfgDataHit)
      else $error("low base index decode wrong");

   high_base_data_a: assert property (
      cfgValid && cfg.baseSel && ioValid && ioAddr == CFG_BASE_HIGH + 16'h0001 |-> cfgDataHit && !cfgIndexHit)
      else $error("high base data decode wrong");

   foreign_base_a: assert property (
      cfgValid && !cfg.baseSel && ioValid && ioAddr[15:1] == CFG_BASE_HIGH[15:1] |-> !cfgIndexHit && !cfgDataHit)
      else $error("unselected base decoded");

   // Nothing is decoded before a strap set exists
   no_early_decode_a: assert property (
      !cfgValid |-> !cfgIndexHit && !cfgDataHit && !testModeActive)
      else $error("decode active before capture");

   capture_to_run_a: assert property (
      capturePulse |=> cfgValid)
      else $error("capture did not reach run state");

   test_strap_low_a: assert property (
      capturePulse && !testPinIn |=> !testModeActive)
      else $error("test mode entered with strap low");

   power_straps_capture_a: assert property (
      capturePulse |=> cfg.pled0 == $past(power_led_pin_cfg_strap0) && cfg.pled1 == $past(power_led_pin_cfg_strap1)
                       && cfg.supplyPol == $past(supply_on_polarity_strap))
      else $error("power straps not captured at reset release");

   sleep_input_a: assert property (
      cfgValid && !gpMode |-> deepSleepStateIn_n == pinDIn && !standbyGpIn2 && !analogIn0Select)
      else $error("sleep input function wrong");

   power_inputs_idle_a: assert property (
      cfgValid && gpMode |-> powerButtonIn_n && deepSleepStateIn_n)
      else $error("power inputs not idle in standby mode");

   standby_outputs_a: assert property (
      cfgValid && gpMode |-> pinAOut == ctrl_q[CT_GPOUT0] && pinBOut == ctrl_q[CT_GPOUT1])
      else $error("standby outputs wrong");

   // Serial pins only after capture, so the pulls set the straps
   pins_released_a: assert property (
      !cfgValid |-> !pinAOe && !pinBOe && !baseSelPinOe && !testPinOe)
      else $error("pin driven before capture");

   baud_out_a: assert property (
      cfgValid && uartBaudSel |-> baseSelPinOe && baseSelPinOut == uartBaudClk)
      else $error("baud output wrong");

   term_ready_a: assert property (
      cfgValid && !uartBaudSel |-> baseSelPinOe && baseSelPinOut == !uartTermReady)
      else $error("terminal ready output wrong");

   rts_follow_a: assert property (
      cfgValid |-> testPinOe && testPinOut == !uartReqToSend)
      else $error("request-to-send output wrong");

   ctrl_write_a: assert property (regWrite && regAddr == REG_CTRL |=> ctrl_q == $past(regWdata))
      else $error("control write lost");

   read_idle_zero_a: assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data not cleared");
endmodule // rscl_strap_config_latch

`default_nettype wire

//--- bench/rscl_board_model.sv
// Board model: strap pull resistors and the system reset source.
// Assumes the bench pulses startRst for one cycle to run a system reset.
`timescale 1ns/1ps
`default_nettype none

module rscl_board_model (
   // Clock and command
   input  wire logic                   clk,
   input  wire logic                   startRst,
   input  wire rscl_pkg::rscl_straps_t strapCfg,
   // Dual-use pins as driven by the device
   input  wire logic                   baseSelPinOut,
   input  wire logic                   baseSelPinOe,
   input  wire logic                   testPinOut,
   input  wire logic                   testPinOe,
   // Board side
   output logic                        sysReset_n,
   output wire logic                   baseSelPinIn,
   output wire logic                   testPinIn,
   output wire logic                   power_led_pin_cfg_strap0,
   output wire logic                   power_led_pin_cfg_strap1,
   output wire logic                   supply_on_polarity_strap
);
   import rscl_pkg::*;
   logic [1:0] cnt_q = 2'h0;
   initial sysReset_n = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   // Low for two cycles, then released
   always @(posedge clk) begin
      if (startRst) begin
         sysReset_n <= 1'b0;
         cnt_q <= 2'h2;
      end else if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
         if (cnt_q == 2'h1) sysReset_n <= 1'b1;
      end
   end
   // Pulls win only while the device leaves the pin released
   assign baseSelPinIn = baseSelPinOe ? baseSelPinOut : strapCfg.baseSel;
   assign testPinIn = testPinOe ? testPinOut : strapCfg.test;
   assign power_led_pin_cfg_strap0 = strapCfg.pled0;
   assign power_led_pin_cfg_strap1 = strapCfg.pled1;
   assign supply_on_polarity_strap = strapCfg.supplyPol;
endmodule // rscl_board_model
`default_nettype wire

//--- bench/rscl_strap_config_latch_tb.sv
// Self-checking bench for the strap configuration latch.
// Assumes the board model owns system reset and the strap pulls.
`timescale 1ns/1ps
`default_nettype none

module rscl_strap_config_latch_tb;
   import rscl_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, startRst = 1'b0, ioValid = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic uartTermReady = 1'b0, uartReqToSend = 1'b0, uartBaudSel = 1'b0, uartBaudClk = 1'b0;
   logic pinCIn = 1'b1, pinDIn = 1'b1;
   logic [15:0] ioAddr = 16'h0000;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, rd;
   rscl_straps_t strapCfg = STRAPS_RESET;
   wire logic sysReset_n, baseSelPinIn, baseSelPinOut, baseSelPinOe, testPinIn, testPinOut, testPinOe;
   wire logic power_led_pin_cfg_strap0, power_led_pin_cfg_strap1, supply_on_polarity_strap;
   wire logic pinAOut, pinAOe, pinBOut, pinBOe, powerButtonIn_n, deepSleepStateIn_n, standbyGpIn2;
   wire logic analogIn0Select, cfgIndexHit, cfgDataHit, testModeActive;
   wire logic [7:0] regRdata;
   int bad_count = 0;
   int checked = 0;
   always #20 clk = ~clk;

   rscl_strap_config_latch DUT (.clk, .reset_n, .sysReset_n, .baseSelPinIn, .baseSelPinOut, .baseSelPinOe,
      .testPinIn, .testPinOut, .testPinOe, .power_led_pin_cfg_strap0, .power_led_pin_cfg_strap1,
      .supply_on_polarity_strap, .uartTermReady, .uartReqToSend, .uartBaudSel, .uartBaudClk, .pinAOut,
      .pinAOe, .pinBOut, .pinBOe, .pinCIn, .pinDIn, .powerButtonIn_n, .deepSleepStateIn_n, .standbyGpIn2,
      .analogIn0Select, .ioValid, .ioAddr, .cfgIndexHit, .cfgDataHit, .testModeActive, .regAddr,
      .regWdata, .regWrite, .regRead, .regRdata);
   rscl_board_model board (.clk, .startRst, .strapCfg, .baseSelPinOut, .baseSelPinOe, .testPinOut,
      .testPinOe, .sysReset_n, .baseSelPinIn, .testPinIn, .power_led_pin_cfg_strap0,
      .power_led_pin_cfg_strap1, .supply_on_polarity_strap);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("Counts: %0d checked, %0d mismatched", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic reg_io(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= wr;
      regRead <= !wr;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      #1;
      rd = regRdata;
   endtask
   // System reset through the board, then bounded wait for the pins to be taken over
   task automatic boot(input rscl_straps_t s);
      int n;
      @(posedge clk);
      strapCfg <= s;
      startRst <= 1'b1;
      @(posedge clk);
      startRst <= 1'b0;
      @(posedge clk);
      #1;
      for (n = 0; n < 20 && baseSelPinOe !== 1'b1; n++) @(posedge clk) #1;
      if (n == 20) begin
         chk("capture done", 8'h01, baseSelPinOe);
         test_done();
      end
   endtask
   task automatic probe(input logic [15:0] a, input logic ei, input logic ed);
      @(posedge clk);
      ioValid <= 1'b1;
      ioAddr <= a;
      #1;
      chk("index hit", ei, cfgIndexHit);
      chk("data hit", ed, cfgDataHit);
   endtask
   task automatic pins(input logic c, input logic d);
      @(posedge clk);
      pinCIn <= c;
      pinDIn <= d;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_low;
      boot(5'h00);
      probe(16'h002e, 1'b1, 1'b0);
      probe(16'h002f, 1'b0, 1'b1);
      probe(16'h004e, 1'b0, 1'b0);
      pins(1'b0, 1'b0);
      chk("button in", 8'h00, powerButtonIn_n);
      chk("sleep in", 8'h00, deepSleepStateIn_n);
      chk("gp in2", 8'h00, {standbyGpIn2, analogIn0Select});
      pins(1'b1, 1'b1);
      reg_io(1'b1, REG_CTRL, 8'h01);
      chk("button out", 8'h02, {pinAOe, pinAOut});
      reg_io(1'b1, REG_CTRL, 8'h02);
      chk("supply active", 8'h02, {pinBOe, pinBOut});
      reg_io(1'b1, REG_CTRL, 8'h00);
      chk("supply idle oe", 8'h00, pinBOe);
      $display("test low straps done");
   endtask
   task automatic t_high;
      boot(5'h07);
      probe(16'h004e, 1'b1, 1'b0);
      probe(16'h004f, 1'b0, 1'b1);
      probe(16'h002e, 1'b0, 1'b0);
      pins(1'b0, 1'b1);
      chk("gp in2 low", 8'h00, standbyGpIn2);
      pins(1'b1, 1'b1);
      chk("gp in2 high", 8'h01, standbyGpIn2);
      chk("analog sel", 8'h03, {analogIn0Select, powerButtonIn_n});
      reg_io(1'b1, REG_CTRL, 8'h0c);
      chk("gp outs", 8'h0f, {pinAOe, pinAOut, pinBOe, pinBOut});
      @(posedge clk);
      strapCfg <= 5'h18;
      reg_io(1'b1, 8'h08, 8'hff);
      reg_io(1'b0, 8'h08, 8'h00);
      chk("unmapped", 8'h00, rd);
      reg_io(1'b0, REG_STATUS, 8'h00);
      chk("status held", 8'h27, rd & 8'h3f);
      chk("test held", 8'h00, testModeActive);
      $display("test high straps done");
   endtask
   task automatic t_test;
      boot(5'h18);
      chk("test mode", 8'h01, testModeActive);
      reg_io(1'b0, REG_STATUS, 8'h00);
      chk("status", 8'h38, rd & 8'h3f);
      reg_io(1'b1, REG_CTRL, 8'h02);
      chk("supply active", 8'h03, {pinBOe, pinBOut});
      reg_io(1'b1, REG_CTRL, 8'h00);
      chk("supply idle", 8'h02, {pinBOe, pinBOut});
      $display("test strap done");
   endtask
   task automatic t_serial;
      @(posedge clk);
      uartTermReady <= 1'b1;
      uartReqToSend <= 1'b1;
      #1;
      chk("ready pin", 8'h02, {baseSelPinOe, baseSelPinOut});
      chk("rts pin", 8'h02, {testPinOe, testPinOut});
      @(posedge clk);
      uartTermReady <= 1'b0;
      uartReqToSend <= 1'b0;
      #1;
      chk("ready idle", 8'h03, {baseSelPinOe, baseSelPinOut});
      chk("rts idle", 8'h03, {testPinOe, testPinOut});
      @(posedge clk);
      uartBaudSel <= 1'b1;
      uartBaudClk <= 1'b0;
      #1;
      chk("baud out", 8'h02, {baseSelPinOe, baseSelPinOut});
      $display("test serial pins done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_low();
      t_high();
      t_test();
      t_serial();
      test_done();
   end
endmodule // rscl_strap_config_latch_tb
`default_nettype wire
